// File: rtl/core_pll_ratio_decode.sv
// Top of the core clock ratio decoder: captures the core ratio field
// of the low reset configuration word once and holds the result.
// Assumes the configuration word is stable when ARST_N is released.
//
// Summary of operation
// - Field sets core to bus clock ratio.
// - Zero multiplier and half-step bits select PLL bypass.
// - Divider bits: 00 gives 2, 01 gives 4.
// - Ratio codes give 1:1 through 3:1.
// - Core PLL referenced to system bus clock.
// - Both PLLs share input, configured apart.
`timescale 1ns/1ps
`default_nettype none
`include "core_pll_ratio_defs.svh"
module core_pll_ratio_decode
   import core_pll_ratio_pkg::*;
(
   input  wire logic                     CLK,
   input  wire logic                     ARST_N,
   input  wire logic [`CRF_WIDTH-1:0]    RESET_CONFIG_WORD_LOW_CORE,
   input  wire logic [3:0]               SYSTEM_PLL_MULTIPLIER,
   output var  logic                     CFG_VALID,
   output var  logic                     CORE_PLL_ENABLE,
   output var  logic                     CORE_PLL_BYPASS,
   output var  logic                     CFG_RESERVED,
   output var  logic [`RATIO_HALF_W-1:0] CORE_RATIO_HALF,
   output var  logic [`VDIV_VAL_W-1:0]   VCO_DIVIDER,
   output var  logic                     CORE_PLL_REF_IS_BUS,
   output var  logic [3:0]               SYSTEM_PLL_MULT_OUT
);
   // ---------------------------------------------------------------
   // Local signals
   // ---------------------------------------------------------------
   cfg_state_e               state;
   cfg_state_e               next_state;
   ratio_decode_if           dec ();

   // Next values of the held outputs. Each register below is a plain
   // load of one of these, which keeps the clocked processes trivial.
   logic                     next_cfg_valid;
   logic                     next_pll_enable;
   logic                     next_pll_bypass;
   logic                     next_cfg_reserved;
   logic [`RATIO_HALF_W-1:0] next_ratio_half;
   logic [`VDIV_VAL_W-1:0]   next_vco_divider;
   logic                     next_ref_is_bus;
   logic [3:0]               next_sys_mult;

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // The three mode flags each compare the decoded mode with one code.
   // Sharing the compare keeps them from looking at different encodings.
   function automatic logic mode_is(clk_mode_e seen,
                                    clk_mode_e want);
      return (seen == want);
   endfunction

   // Load on the capture edge, hold otherwise; one function per width.
   // Every output follows the same policy, so it is changed in one place.
   function automatic logic take1(logic load,
                                  logic fresh,
                                  logic held);
      return load ? fresh : held;
   endfunction

   function automatic logic [2:0] take3(logic       load,
                                        logic [2:0] fresh,
                                        logic [2:0] held);
      return load ? fresh : held;
   endfunction

   function automatic logic [3:0] take4(logic       load,
                                        logic [3:0] fresh,
                                        logic [3:0] held);
      return load ? fresh : held;
   endfunction

   // ---------------------------------------------------------------
   // Field decode
   // ---------------------------------------------------------------
   // The lookup is purely combinational and runs every cycle. Its result
   // only matters on the capture edge, so the field pins may move freely
   // at any other time without disturbing the clock hardware.
   ratio_table u_table (
      .dec (dec)
   );

   assign dec.field = RESET_CONFIG_WORD_LOW_CORE;

   // Ratios travel in half steps: 2 is 1:1, 3 is 1.5:1, 4 is 2:1, 5 is
   // 2.5:1 and 6 is 3:1. Zero marks bypass or a reserved code.
   wire mode_pll    = mode_is(dec.mode, MODE_PLL);
   wire mode_bypass = mode_is(dec.mode, MODE_BYPASS);
   wire mode_rsvd   = mode_is(dec.mode, MODE_RSVD);

   // ---------------------------------------------------------------
   // Capture sequence
   // ---------------------------------------------------------------
   // The field is taken on the second edge after reset release. The
   // first edge only moves the sequence out of its reset state, which
   // keeps the capture clear of the asynchronous release itself. The
   // field must therefore be steady from release through that edge.
   wire capture = (state == ST_CAPTURE);

   // ST_HOLD is left only through reset, so a second capture cannot
   // happen by accident. An illegal state code falls back to ST_RESET.
   always_comb begin
      case (state)
         ST_RESET:   next_state = ST_CAPTURE;
         ST_CAPTURE: next_state = ST_HOLD;
         ST_HOLD:    next_state = ST_HOLD;
         default:    next_state = ST_RESET;
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // Next values
   // ---------------------------------------------------------------
   // Away from the capture edge every next value is the held one, which
   // freezes the result until the next reset.
   assign next_cfg_valid    = take1(capture, 1'b1, CFG_VALID);
   assign next_pll_enable   = take1(capture, mode_pll, CORE_PLL_ENABLE);
   assign next_pll_bypass   = take1(capture, mode_bypass, CORE_PLL_BYPASS);
   assign next_cfg_reserved = take1(capture, mode_rsvd, CFG_RESERVED);
   assign next_ratio_half   = take3(capture, dec.ratio_half, CORE_RATIO_HALF);
   assign next_vco_divider  = take3(capture, dec.vco_div, VCO_DIVIDER);
   assign next_ref_is_bus   = take1(capture, 1'b1, CORE_PLL_REF_IS_BUS);
   assign next_sys_mult     = take4(capture, SYSTEM_PLL_MULTIPLIER,
                                    SYSTEM_PLL_MULT_OUT);

   // ---------------------------------------------------------------
   // Held results
   // ---------------------------------------------------------------
   // Outputs stay at the safe off value until the capture edge, so the
   // clock hardware never sees a half-decoded ratio. Each register has
   // its own short process; all of them load on the same edge.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CFG_VALID <= 1'b0;
      end else begin
         CFG_VALID <= next_cfg_valid;
      end
   end

   // The core PLL runs only for a listed ratio and divider.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CORE_PLL_ENABLE <= 1'b0;
      end else begin
         CORE_PLL_ENABLE <= next_pll_enable;
      end
   end

   // In bypass the core PLL is off and the core runs on the bus clock.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CORE_PLL_BYPASS <= 1'b0;
      end else begin
         CORE_PLL_BYPASS <= next_pll_bypass;
      end
   end

   // A reserved code leaves both the core PLL and the bypass off, so the
   // clock hardware keeps the core stopped rather than guess a ratio.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CFG_RESERVED <= 1'b0;
      end else begin
         CFG_RESERVED <= next_cfg_reserved;
      end
   end

   // Held at zero for bypass and reserved codes.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CORE_RATIO_HALF <= `RATIO_RESET;
      end else begin
         CORE_RATIO_HALF <= next_ratio_half;
      end
   end

   // Two or four for a running PLL, zero otherwise.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         VCO_DIVIDER <= `VDIV_RESET;
      end else begin
         VCO_DIVIDER <= next_vco_divider;
      end
   end

   // The core PLL always takes the bus clock as its reference, never the
   // shared input clock directly.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CORE_PLL_REF_IS_BUS <= 1'b0;
      end else begin
         CORE_PLL_REF_IS_BUS <= next_ref_is_bus;
      end
   end

   // The system multiplier is captured on the same edge but decoded by
   // nobody here, so the system PLL is set apart from the core PLL.
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SYSTEM_PLL_MULT_OUT <= 4'h0;
      end else begin
         SYSTEM_PLL_MULT_OUT <= next_sys_mult;
      end
   end
endmodule
`default_nettype wire

// File: rtl/core_pll_ratio_defs.svh
// Constants for the core clock ratio decoder.
// Assumes inclusion by bare name from rtl/ sources only.
`ifndef CORE_PLL_RATIO_DEFS_SVH
`define CORE_PLL_RATIO_DEFS_SVH

// ----------------------------------------------------------------------
// Field layout of the core ratio field
// ----------------------------------------------------------------------
`define CRF_WIDTH        7
`define CRF_VDIV_LSB     0
`define CRF_VDIV_MSB     1
`define CRF_MULT_LSB     2
`define CRF_MULT_MSB     5
`define CRF_HALF_BIT     6

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define VDIV_CODE_2      2'h0
`define VDIV_CODE_4      2'h1
`define VDIV_CODE_RSVD   2'h3
`define MULT_BYPASS      4'h0
`define MULT_MAX         4'h3

// Ratio in half steps: 2 = 1:1, 3 = 1.5:1 ... 6 = 3:1.
`define RATIO_HALF_W     3
`define RATIO_RESET      3'h0
`define VDIV_VAL_W       3
`define VDIV_VAL_2       3'h2
`define VDIV_VAL_4       3'h4
`define VDIV_RESET       3'h0

`endif

// File: rtl/core_pll_ratio_pkg.sv
// Types shared by the core ratio decoder files.
// Assumes core_pll_ratio_defs.svh is on the include path.
`default_nettype none
`include "core_pll_ratio_defs.svh"
package core_pll_ratio_pkg;
   typedef enum logic [2:0] {
      ST_RESET   = 3'h1,
      ST_CAPTURE = 3'h2,
      ST_HOLD    = 3'h4
   } cfg_state_e;

   typedef enum logic [1:0] {
      MODE_OFF    = 2'h0,
      MODE_BYPASS = 2'h1,
      MODE_PLL    = 2'h2,
      MODE_RSVD   = 2'h3
   } clk_mode_e;
endpackage
`default_nettype wire

// File: rtl/ratio_decode_if.sv
// Carries one decoded core ratio word between decoder modules.
// Assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "core_pll_ratio_defs.svh"
interface ratio_decode_if;
   import core_pll_ratio_pkg::*;
   logic [`CRF_WIDTH-1:0]    field;
   clk_mode_e                mode;
   logic [`RATIO_HALF_W-1:0] ratio_half;
   logic [`VDIV_VAL_W-1:0]   vco_div;
   modport table_side (input field, output mode, ratio_half, vco_div);
   modport user_side  (output field, input mode, ratio_half, vco_div);
endinterface
`default_nettype wire

// File: rtl/ratio_table.sv
// Combinational lookup of the core ratio field.
// Assumes the field is stable while it is being decoded.
`timescale 1ns/1ps
`default_nettype none
`include "core_pll_ratio_defs.svh"
module ratio_table
   import core_pll_ratio_pkg::*;
(
   ratio_decode_if.table_side dec
);
   wire [1:0] vdiv_code = dec.field[`CRF_VDIV_MSB:`CRF_VDIV_LSB];
   wire [3:0] mult_code = dec.field[`CRF_MULT_MSB:`CRF_MULT_LSB];
   wire       half_bit  = dec.field[`CRF_HALF_BIT];

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire is_bypass = (mult_code == `MULT_BYPASS) && !half_bit;
   wire vdiv_ok   = (vdiv_code != `VDIV_CODE_RSVD);
   // Multiplier 3 has no half step, so 3.5:1 is reserved.
   wire mult_ok   = (mult_code != `MULT_BYPASS)
                 && (mult_code <= `MULT_MAX)
                 && !(mult_code == `MULT_MAX && half_bit);
   wire div_ok    = (vdiv_code == `VDIV_CODE_2)
                 || (vdiv_code == `VDIV_CODE_4);

   assign dec.mode = is_bypass ? MODE_BYPASS :
                     (mult_ok && div_ok && vdiv_ok) ? MODE_PLL : MODE_RSVD;
   assign dec.ratio_half = (dec.mode == MODE_PLL) ?
          {mult_code[1:0], half_bit} : `RATIO_RESET;
   assign dec.vco_div = (dec.mode != MODE_PLL) ? `VDIV_RESET :
          (vdiv_code == `VDIV_CODE_4) ? `VDIV_VAL_4 : `VDIV_VAL_2;
endmodule
`default_nettype wire

// File: bench/cfg_word_loader.sv
// Model of the loader that presents the configuration word fields.
// Assumes the bench chooses the values, reserved ones included.
`timescale 1ns/1ps
`default_nettype none
module cfg_word_loader (
   input  wire logic       CLK,
   input  wire logic [6:0] load_field,
   input  wire logic [3:0] load_mult,
   output var  logic [6:0] field,
   output var  logic [3:0] mult
);
   always_ff @(posedge CLK) begin
      field <= load_field;
      mult  <= load_mult;
   end
endmodule
`default_nettype wire

// File: bench/core_pll_ratio_decode_asserts.sv
// Checker for the core ratio decoder, seeing only its top ports.
// Assumes one clock domain and an asynchronous active low reset.
`timescale 1ns/1ps
`default_nettype none
module core_pll_ratio_decode_asserts (
   input  wire logic       CLK,
   input  wire logic       ARST_N,
   input  wire logic [6:0] RESET_CONFIG_WORD_LOW_CORE,
   input  wire logic [3:0] SYSTEM_PLL_MULTIPLIER,
   input  wire logic       CFG_VALID,
   input  wire logic       CORE_PLL_ENABLE,
   input  wire logic       CORE_PLL_BYPASS,
   input  wire logic       CFG_RESERVED,
   input  wire logic [2:0] CORE_RATIO_HALF,
   input  wire logic [2:0] VCO_DIVIDER,
   input  wire logic       CORE_PLL_REF_IS_BUS,
   input  wire logic [3:0] SYSTEM_PLL_MULT_OUT
);
   logic [1:0] cnt;
   logic [6:0] cap;
   logic [3:0] capm;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt <= 2'h0;
      end else if (cnt != 2'h3) begin
         cnt <= cnt + 2'h1;
      end
   end
   always_ff @(posedge CLK) begin
      if (cnt == 2'h1) begin
         cap  <= RESET_CONFIG_WORD_LOW_CORE;
         capm <= SYSTEM_PLL_MULTIPLIER;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   chk_valid_timing: assert property (CFG_VALID == cnt[1])
      else $error("valid flag at wrong edge");
   chk_hold_stable: assert property (cnt[1] |=>
      $stable({CFG_VALID, CORE_PLL_ENABLE, CORE_PLL_BYPASS, CFG_RESERVED,
      CORE_RATIO_HALF, VCO_DIVIDER, CORE_PLL_REF_IS_BUS,
      SYSTEM_PLL_MULT_OUT}))
      else $error("decoded result changed after capture");
   chk_bypass_code: assert property (cnt[1] |->
      CORE_PLL_BYPASS == (cap[6:2] == 5'h00))
      else $error("bypass does not follow field");
   chk_div_map: assert property (CORE_PLL_ENABLE |->
      VCO_DIVIDER == (cap[1:0] == 2'h0 ? 3'h2 : 3'h4))
      else $error("divider mismatch");
   chk_ratio_map: assert property (CORE_PLL_ENABLE |->
      cap[5:4] == 2'h0 && CORE_RATIO_HALF == {cap[3:2], cap[6]})
      else $error("ratio mismatch");
   chk_mode_onehot: assert property (cnt[1] |->
      $onehot({CORE_PLL_ENABLE, CORE_PLL_BYPASS, CFG_RESERVED}))
      else $error("mode flags not exclusive");
   chk_ref_bus: assert property (cnt[1] |-> CORE_PLL_REF_IS_BUS)
      else $error("core reference not bus clock");
   chk_sys_mult: assert property (cnt[1] |->
      SYSTEM_PLL_MULT_OUT == capm)
      else $error("system multiplier not kept apart");
   cover property (CORE_PLL_BYPASS);
   cover property (CFG_RESERVED);
   cover property (CORE_PLL_ENABLE && CORE_RATIO_HALF == 3'h6);
endmodule
bind core_pll_ratio_decode core_pll_ratio_decode_asserts chk (.CLK(CLK),
   .ARST_N(ARST_N), .RESET_CONFIG_WORD_LOW_CORE(RESET_CONFIG_WORD_LOW_CORE),
   .SYSTEM_PLL_MULTIPLIER(SYSTEM_PLL_MULTIPLIER), .CFG_VALID(CFG_VALID),
   .CORE_PLL_ENABLE(CORE_PLL_ENABLE), .CORE_PLL_BYPASS(CORE_PLL_BYPASS),
   .CFG_RESERVED(CFG_RESERVED), .CORE_RATIO_HALF(CORE_RATIO_HALF),
   .VCO_DIVIDER(VCO_DIVIDER), .CORE_PLL_REF_IS_BUS(CORE_PLL_REF_IS_BUS),
   .SYSTEM_PLL_MULT_OUT(SYSTEM_PLL_MULT_OUT));
`default_nettype wire

// File: bench/core_pll_ratio_decode_tb.sv
// Self-checking bench for the core ratio decoder.
// Assumes the loader model presents each field one cycle after it is set.
`timescale 1ns/1ps
`default_nettype none
module core_pll_ratio_decode_tb;
   logic        CLK = 1'b0, ARST_N = 1'b0;
   logic [6:0]  ld_f = 7'h00, f;
   logic [3:0]  ld_m = 4'h0, m, mo;
   logic        v, en, byp, rsv, rb;
   logic [2:0]  rh, vd;
   int          error_cnt = 0, check_count = 0, cyc = 0;
   wire  [14:0] outs = {v, en, byp, rsv, rh, vd, rb, mo};
   initial forever #5 CLK = ~CLK;
   cfg_word_loader ldr (.CLK(CLK), .load_field(ld_f), .load_mult(ld_m),
      .field(f), .mult(m));
   core_pll_ratio_decode uut (.CLK(CLK), .ARST_N(ARST_N),
      .RESET_CONFIG_WORD_LOW_CORE(f), .SYSTEM_PLL_MULTIPLIER(m),
      .CFG_VALID(v), .CORE_PLL_ENABLE(en), .CORE_PLL_BYPASS(byp),
      .CFG_RESERVED(rsv), .CORE_RATIO_HALF(rh), .VCO_DIVIDER(vd),
      .CORE_PLL_REF_IS_BUS(rb), .SYSTEM_PLL_MULT_OUT(mo));
   function automatic logic [14:0] expect_out(logic [6:0] fv, logic [3:0] mv);
      logic b, ok;
      b  = fv[6:2] == 5'h00;
      ok = !b && !fv[1] && fv[5:4] == 2'h0 && fv[3:2] != 2'h0
           && !(fv[3:2] == 2'h3 && fv[6]);
      return {1'b1, ok, b, !ok && !b, ok ? {fv[3:2], fv[6]} : 3'h0,
              ok ? (fv[0] ? 3'h4 : 3'h2) : 3'h0, 1'b1, mv};
   endfunction
   task automatic check(string name, logic [14:0] seen, logic [14:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One reset per word: captured result must survive later input noise.
   task automatic run(logic [6:0] fv, logic [3:0] mv);
      logic [14:0] e;
      e = expect_out(fv, mv);
      @(posedge CLK);
      ARST_N <= 1'b0;
      ld_f <= fv;
      ld_m <= mv;
      repeat (3) @(posedge CLK);
      ARST_N <= 1'b1;
      repeat (3) @(posedge CLK);
      #1;
      check("flags", outs & 15'h7800, e & 15'h7800);
      check("ratio", outs & 15'h0700, e & 15'h0700);
      check("divider", outs & 15'h00E0, e & 15'h00E0);
      check("links", outs & 15'h001F, e & 15'h001F);
      @(posedge CLK);
      ld_f <= 7'($urandom);
      ld_m <= 4'($urandom);
      repeat (3) @(posedge CLK);
      #1 check("hold", outs, e);
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc > 5000) begin
         error_cnt++;
         finish_test();
      end
   end
   initial begin
      void'($urandom(32'h00F1670A));
      repeat (20) @(posedge CLK);
      run(7'h04, 4'h4);
      run(7'h7F, 4'hF);
      for (int i = 0; i < 128; i++) run(7'(i), 4'($urandom));
      finish_test();
   end
endmodule
`default_nettype wire
